/* include/skip_alu_pkg.sv */
// What this block does
// - Rotate right through carry into accumulator
// - Subtract with borrow into accumulator, flags
// - Subtract with borrow into memory, flags
// - Decrement memory, skip when zero
// - Decrement into accumulator, skip when zero
// - Skip discards prefetch, adds dummy cycle
// - Set whole byte to ones
// - Set one selected bit
// - Increment memory, skip when zero
// - Increment into accumulator, skip when zero
// - Skip when selected bit is one
// - Subtract memory into accumulator, flags
// - Subtract memory into memory, flags
// - Subtract immediate into accumulator, flags
// - Swap nibbles of memory in place
// - Timer, timeout, powerdown bits never altered
`default_nettype none
package skip_alu_pkg;

  localparam int BYTE_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int LSB_POS = 0;
  localparam int BIT_SEL_W = 3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ACC_RESET = 8'h00;

  typedef enum logic [3:0] {
    rotate_right_through_flag_to_acc = 4'h0,
    subtract_with_borrow_to_acc = 4'h1,
    subtract_with_borrow_to_mem = 4'h2,
    decrement_skip_zero = 4'h3,
    decrement_to_acc_skip_zero = 4'h4,
    set_byte = 4'h5,
    set_bit = 4'h6,
    increment_skip_zero = 4'h7,
    increment_to_acc_skip_zero = 4'h8,
    skip_if_bit_one = 4'h9,
    subtract_to_acc = 4'hA,
    difference_to_mem = 4'hB,
    subtract_immediate = 4'hC,
    swap_nibbles = 4'hD
  } op_code_type;

  typedef struct packed {
    op_code_type code;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic [BYTE_W-1:0] operand;
    logic [BYTE_W-1:0] literal;
  } op_req_type;

  typedef struct packed {
    logic timer_flag_two;
    logic timer_flag_one;
    logic timeout_bit;
    logic powerdown_bit;
    logic sign_wrap_bit;
    logic zero_bit;
    logic nibble_carry_bit;
    logic carry_bit;
  } status_type;

  localparam status_type STATUS_RESET = '0;

  typedef struct packed {
    logic we;
    logic [BYTE_W-1:0] data;
  } mem_wr_type;

endpackage
`default_nettype wire

/* rtl/complement_adder.sv */
`timescale 1ns/100ps
`default_nettype none
module complement_adder (
  input wire logic [skip_alu_pkg::BYTE_W-1:0] a,
  input wire logic [skip_alu_pkg::BYTE_W-1:0] b,
  input wire logic carry_in,
  output logic [skip_alu_pkg::BYTE_W-1:0] sum,
  output logic carry_out,
  output logic nibble_carry,
  output logic sign_wrap
);
  import skip_alu_pkg::*;

  logic [BYTE_W-1:0] b_inv;
  logic [BYTE_W:0] full;
  logic [NIBBLE_W:0] low;

  // a + ~b + carry_in; carry out is the no-borrow indication
  assign b_inv = ~b;
  assign full = {1'b0, a} + {1'b0, b_inv} + {{BYTE_W{1'b0}}, carry_in};
  assign low = {1'b0, a[NIBBLE_W-1:0]} + {1'b0, b_inv[NIBBLE_W-1:0]} + {{NIBBLE_W{1'b0}}, carry_in};
  assign sum = full[BYTE_W-1:0];
  assign carry_out = full[BYTE_W];
  assign nibble_carry = low[NIBBLE_W];
  assign sign_wrap = (a[BYTE_W-1] == b_inv[BYTE_W-1]) && (sum[BYTE_W-1] != a[BYTE_W-1]);

endmodule // complement_adder
`default_nettype wire

/* rtl/skip_alu.sv */
`timescale 1ns/100ps
`default_nettype none
module skip_alu (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic op_valid,
  output logic op_ready,
  input wire skip_alu_pkg::op_req_type op_req,
  output skip_alu_pkg::mem_wr_type mem_wr,
  output logic [skip_alu_pkg::BYTE_W-1:0] acc,
  output skip_alu_pkg::status_type status,
  output logic skip_dummy
);
  import skip_alu_pkg::*;

  logic [BYTE_W-1:0] acc_q, acc_d;
  status_type status_q, status_d;
  mem_wr_type mem_wr_q, mem_wr_d;
  logic skip_q, skip_d;
  logic take;
  logic [BYTE_W-1:0] add_b, add_sum, inc_val, dec_val, bit_mask;
  logic add_cin, add_c, add_ac, add_ov;

  // ---------------------------------------------------------------
  // Operand preparation
  // ---------------------------------------------------------------
  // A skip holds off the next request for one dummy cycle
  assign op_ready = !skip_q;
  assign take = op_valid && op_ready;

  assign add_b = (op_req.code == subtract_immediate) ? op_req.literal : op_req.operand;
  assign add_cin = (op_req.code == subtract_with_borrow_to_acc ||
                    op_req.code == subtract_with_borrow_to_mem) ? status_q.carry_bit : 1'b1;
  assign inc_val = op_req.operand + BYTE_ONE;
  assign dec_val = op_req.operand - BYTE_ONE;
  assign bit_mask = BYTE_ONE << op_req.bit_sel;

  complement_adder u_adder (
    .a(acc_q),
    .b(add_b),
    .carry_in(add_cin),
    .sum(add_sum),
    .carry_out(add_c),
    .nibble_carry(add_ac),
    .sign_wrap(add_ov)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    status_d = status_q;
    mem_wr_d.we = 1'b0;
    mem_wr_d.data = mem_wr_q.data;
    skip_d = 1'b0;
    if (take) begin
      case (op_req.code)
        rotate_right_through_flag_to_acc: begin
          acc_d = {status_q.carry_bit, op_req.operand[BYTE_W-1:LSB_POS+1]};
          status_d.carry_bit = op_req.operand[LSB_POS];
        end
        subtract_with_borrow_to_acc, subtract_to_acc, subtract_immediate: begin
          acc_d = add_sum;
          status_d.sign_wrap_bit = add_ov;
          status_d.zero_bit = (add_sum == ZERO_BYTE);
          status_d.nibble_carry_bit = add_ac;
          status_d.carry_bit = add_c;
        end
        subtract_with_borrow_to_mem, difference_to_mem: begin
          mem_wr_d.we = 1'b1;
          mem_wr_d.data = add_sum;
          status_d.sign_wrap_bit = add_ov;
          status_d.zero_bit = (add_sum == ZERO_BYTE);
          status_d.nibble_carry_bit = add_ac;
          status_d.carry_bit = add_c;
        end
        decrement_skip_zero: begin
          mem_wr_d.we = 1'b1;
          mem_wr_d.data = dec_val;
          skip_d = (dec_val == ZERO_BYTE);
        end
        decrement_to_acc_skip_zero: begin
          acc_d = dec_val;
          skip_d = (dec_val == ZERO_BYTE);
        end
        set_byte: begin
          mem_wr_d.we = 1'b1;
          mem_wr_d.data = ALL_ONES;
        end
        set_bit: begin
          mem_wr_d.we = 1'b1;
          mem_wr_d.data = op_req.operand | bit_mask;
        end
        increment_skip_zero: begin
          mem_wr_d.we = 1'b1;
          mem_wr_d.data = inc_val;
          skip_d = (inc_val == ZERO_BYTE);
        end
        increment_to_acc_skip_zero: begin
          acc_d = inc_val;
          skip_d = (inc_val == ZERO_BYTE);
        end
        skip_if_bit_one: begin
          skip_d = op_req.operand[op_req.bit_sel];
        end
        swap_nibbles: begin
          mem_wr_d.we = 1'b1;
          mem_wr_d.data = {op_req.operand[NIBBLE_W-1:LSB_POS], op_req.operand[BYTE_W-1:NIBBLE_W]};
        end
        default: begin
          skip_d = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // The upper four status bits are only ever copied, never written
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= ACC_RESET;
      status_q <= STATUS_RESET;
      mem_wr_q <= '0;
      skip_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      status_q <= status_d;
      mem_wr_q <= mem_wr_d;
      skip_q <= skip_d;
    end
  end

  assign acc = acc_q;
  assign status = status_q;
  assign mem_wr = mem_wr_q;
  assign skip_dummy = skip_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence taken_seq(op_code_type c);
    op_valid && op_ready && op_req.code == c;
  endsequence

  sequence dummy_seq;
    skip_q && !op_ready ##1 !skip_q && op_ready;
  endsequence

  sequence unchanged_seq;
    acc_q == $past(acc_q) && status_q == $past(status_q) && !mem_wr_q.we && !skip_q;
  endsequence

  rotate_acc_a: assert property (taken_seq(rotate_right_through_flag_to_acc) |=>
    acc_q == {$past(status_q.carry_bit), $past(op_req.operand[BYTE_W-1:LSB_POS+1])}
    && status_q.carry_bit == $past(op_req.operand[LSB_POS]) && !mem_wr_q.we
    && status_q[BYTE_W-1:1] == $past(status_q[BYTE_W-1:1]))
    else $error("rotate into accumulator wrong");

  borrow_acc_a: assert property (taken_seq(subtract_with_borrow_to_acc) |=>
    acc_q == 8'($past(acc_q) - $past(op_req.operand) - {7'h00, ~$past(status_q.carry_bit)})
    && status_q.zero_bit == (acc_q == ZERO_BYTE))
    else $error("subtract with borrow to accumulator wrong");

  borrow_mem_a: assert property (taken_seq(subtract_with_borrow_to_mem) |=>
    mem_wr_q.we && acc_q == $past(acc_q)
    && mem_wr_q.data == 8'($past(acc_q) - $past(op_req.operand) - {7'h00, ~$past(status_q.carry_bit)}))
    else $error("subtract with borrow to memory wrong");

  dec_skip_a: assert property (taken_seq(decrement_skip_zero) |=>
    mem_wr_q.we && mem_wr_q.data == 8'($past(op_req.operand) - BYTE_ONE)
    && skip_q == ($past(op_req.operand) == BYTE_ONE) && status_q == $past(status_q))
    else $error("decrement and skip wrong");

  dec_acc_a: assert property (taken_seq(decrement_to_acc_skip_zero) |=>
    !mem_wr_q.we && acc_q == 8'($past(op_req.operand) - BYTE_ONE)
    && skip_q == (acc_q == ZERO_BYTE) && status_q == $past(status_q))
    else $error("decrement into accumulator wrong");

  dummy_cycle_a: assert property ($rose(skip_q) |-> dummy_seq)
    else $error("skip did not give exactly one dummy cycle");

  set_byte_a: assert property (taken_seq(set_byte) |=>
    mem_wr_q.we && mem_wr_q.data == ALL_ONES && status_q == $past(status_q))
    else $error("byte set wrong");

  set_bit_a: assert property (taken_seq(set_bit) |=>
    mem_wr_q.we && mem_wr_q.data[$past(op_req.bit_sel)]
    && (mem_wr_q.data & ~$past(bit_mask)) == ($past(op_req.operand) & ~$past(bit_mask)))
    else $error("bit set wrong");

  inc_skip_a: assert property (taken_seq(increment_skip_zero) |=>
    mem_wr_q.we && mem_wr_q.data == 8'($past(op_req.operand) + BYTE_ONE)
    && skip_q == ($past(op_req.operand) == ALL_ONES) && status_q == $past(status_q))
    else $error("increment and skip wrong");

  inc_acc_a: assert property (taken_seq(increment_to_acc_skip_zero) |=>
    !mem_wr_q.we && acc_q == 8'($past(op_req.operand) + BYTE_ONE)
    && skip_q == ($past(op_req.operand) == ALL_ONES))
    else $error("increment into accumulator wrong");

  bit_test_a: assert property (taken_seq(skip_if_bit_one) |=>
    skip_q == $past(op_req.operand[op_req.bit_sel]) && !mem_wr_q.we
    && acc_q == $past(acc_q) && status_q == $past(status_q))
    else $error("bit test skip wrong");

  sub_acc_a: assert property (taken_seq(subtract_to_acc) |=>
    acc_q == 8'($past(acc_q) - $past(op_req.operand)) && !mem_wr_q.we)
    else $error("subtract to accumulator wrong");

  sub_mem_a: assert property (taken_seq(difference_to_mem) |=>
    mem_wr_q.we && mem_wr_q.data == 8'($past(acc_q) - $past(op_req.operand)))
    else $error("subtract to memory wrong");

  sub_imm_a: assert property (taken_seq(subtract_immediate) |=>
    acc_q == 8'($past(acc_q) - $past(op_req.literal))
    && status_q.carry_bit == ($past(acc_q) >= $past(op_req.literal)))
    else $error("subtract immediate wrong");

  swap_nib_a: assert property (taken_seq(swap_nibbles) |=>
    mem_wr_q.we && mem_wr_q.data == {$past(op_req.operand[NIBBLE_W-1:LSB_POS]),
    $past(op_req.operand[BYTE_W-1:NIBBLE_W])} && status_q == $past(status_q))
    else $error("nibble swap wrong");

  upper_flags_a: assert property ($stable(status_q[BYTE_W-1:NIBBLE_W]))
    else $error("timer, timeout or powerdown bit changed");

  no_borrow_a: assert property (taken_seq(subtract_to_acc) or taken_seq(difference_to_mem) |=>
    status_q.carry_bit == ($past(acc_q) >= $past(op_req.operand)))
    else $error("carry does not mean no borrow");

  borrow_carry_a: assert property (taken_seq(subtract_with_borrow_to_acc) or
    taken_seq(subtract_with_borrow_to_mem) |=>
    status_q.carry_bit == ({1'b0, $past(acc_q)} >=
    {1'b0, $past(op_req.operand)} + {8'h00, ~$past(status_q.carry_bit)}))
    else $error("carry after subtract with borrow wrong");

  borrow_acc_flags_a: assert property (taken_seq(subtract_with_borrow_to_acc) |=>
    !mem_wr_q.we && status_q.sign_wrap_bit == ($past(acc_q[BYTE_W-1]) != $past(op_req.operand[BYTE_W-1])
    && acc_q[BYTE_W-1] != $past(acc_q[BYTE_W-1]))
    && status_q.nibble_carry_bit == ({1'b0, $past(acc_q[NIBBLE_W-1:0])} >=
    {1'b0, $past(op_req.operand[NIBBLE_W-1:0])} + {4'h0, ~$past(status_q.carry_bit)}))
    else $error("flags after subtract with borrow to accumulator wrong");

  borrow_mem_flags_a: assert property (taken_seq(subtract_with_borrow_to_mem) |=>
    status_q.zero_bit == (mem_wr_q.data == ZERO_BYTE)
    && status_q.sign_wrap_bit == ($past(acc_q[BYTE_W-1]) != $past(op_req.operand[BYTE_W-1])
    && mem_wr_q.data[BYTE_W-1] != $past(acc_q[BYTE_W-1]))
    && status_q.nibble_carry_bit == ({1'b0, $past(acc_q[NIBBLE_W-1:0])} >=
    {1'b0, $past(op_req.operand[NIBBLE_W-1:0])} + {4'h0, ~$past(status_q.carry_bit)}))
    else $error("flags after subtract with borrow to memory wrong");

  sub_acc_flags_a: assert property (taken_seq(subtract_to_acc) |=>
    status_q.zero_bit == (acc_q == ZERO_BYTE)
    && status_q.sign_wrap_bit == ($past(acc_q[BYTE_W-1]) != $past(op_req.operand[BYTE_W-1])
    && acc_q[BYTE_W-1] != $past(acc_q[BYTE_W-1])))
    else $error("flags after subtract to accumulator wrong");

  sub_mem_flags_a: assert property (taken_seq(difference_to_mem) |=>
    acc_q == $past(acc_q) && status_q.zero_bit == (mem_wr_q.data == ZERO_BYTE)
    && status_q.sign_wrap_bit == ($past(acc_q[BYTE_W-1]) != $past(op_req.operand[BYTE_W-1])
    && mem_wr_q.data[BYTE_W-1] != $past(acc_q[BYTE_W-1])))
    else $error("flags after subtract to memory wrong");

  sub_nibble_a: assert property (taken_seq(subtract_to_acc) or taken_seq(difference_to_mem) |=>
    status_q.nibble_carry_bit == ($past(acc_q[NIBBLE_W-1:0]) >= $past(op_req.operand[NIBBLE_W-1:0])))
    else $error("nibble carry after subtract wrong");

  imm_flags_a: assert property (taken_seq(subtract_immediate) |=>
    !mem_wr_q.we && status_q.zero_bit == ($past(acc_q) == $past(op_req.literal))
    && status_q.nibble_carry_bit == ($past(acc_q[NIBBLE_W-1:0]) >= $past(op_req.literal[NIBBLE_W-1:0]))
    && status_q.sign_wrap_bit == ($past(acc_q[BYTE_W-1]) != $past(op_req.literal[BYTE_W-1])
    && acc_q[BYTE_W-1] != $past(acc_q[BYTE_W-1])))
    else $error("flags after subtract immediate wrong");

  flag_free_a: assert property (take && op_req.code inside {
    decrement_skip_zero, decrement_to_acc_skip_zero, set_byte, set_bit,
    increment_skip_zero, increment_to_acc_skip_zero, skip_if_bit_one, swap_nibbles} |=>
    status_q == $past(status_q))
    else $error("flag changed by an operation that keeps flags");

  mem_write_src_a: assert property (mem_wr_q.we |->
    $past(take) && $past(op_req.code) inside {subtract_with_borrow_to_mem, difference_to_mem,
    decrement_skip_zero, set_byte, set_bit, increment_skip_zero, swap_nibbles})
    else $error("memory write from an operation that does not write");

  skip_src_a: assert property (skip_q |-> $past(take) && $past(op_req.code) inside {
    decrement_skip_zero, decrement_to_acc_skip_zero, increment_skip_zero,
    increment_to_acc_skip_zero, skip_if_bit_one})
    else $error("skip from an operation that cannot skip");

  refused_hold_a: assert property (!take |=> unchanged_seq)
    else $error("state changed without a taken request");

  unknown_code_a: assert property (take && op_req.code > swap_nibbles |=> unchanged_seq)
    else $error("unknown operation changed state");

endmodule // skip_alu
`default_nettype wire

/* sim/skip_alu_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module skip_alu_tb_top;
  import skip_alu_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic op_valid = 1'b0;
  logic op_ready;
  op_req_type op_req = '0;
  mem_wr_type mem_wr;
  logic [7:0] acc;
  status_type status;
  logic skip_dummy;
  logic [7:0] acc_m = 8'h00;
  status_type st_m = STATUS_RESET;
  int error_cnt = 0;
  int samples_checked = 0;

  always #2.5 core_clk = ~core_clk;

  skip_alu dut (.core_clk(core_clk), .resetn(resetn), .op_valid(op_valid), .op_ready(op_ready),
    .op_req(op_req), .mem_wr(mem_wr), .acc(acc), .status(status), .skip_dummy(skip_dummy));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sub_m(input logic [7:0] a, input logic [7:0] b, input logic cin, output logic [7:0] s);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + 9'(cin);
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(cin);
    s = full[7:0];
    st_m.carry_bit = full[8];
    st_m.nibble_carry_bit = low[4];
    st_m.sign_wrap_bit = (a[7] == ~b[7]) && (s[7] != a[7]);
    st_m.zero_bit = (s == 8'h00);
  endtask

  // Holds op_valid high so consecutive calls run back to back
  task automatic run(input op_code_type c, input logic [2:0] bs, input logic [7:0] opd, input logic [7:0] lit);
    logic we;
    logic [7:0] d;
    logic skp;
    we = 1'b0;
    d = 8'h00;
    skp = 1'b0;
    case (c)
      rotate_right_through_flag_to_acc: begin
        acc_m = {st_m.carry_bit, opd[7:1]};
        st_m.carry_bit = opd[0];
      end
      subtract_with_borrow_to_acc: sub_m(acc_m, opd, st_m.carry_bit, acc_m);
      subtract_with_borrow_to_mem: sub_m(acc_m, opd, st_m.carry_bit, d);
      subtract_to_acc: sub_m(acc_m, opd, 1'b1, acc_m);
      difference_to_mem: sub_m(acc_m, opd, 1'b1, d);
      subtract_immediate: sub_m(acc_m, lit, 1'b1, acc_m);
      decrement_skip_zero: d = opd - 8'h01;
      increment_skip_zero: d = opd + 8'h01;
      decrement_to_acc_skip_zero: acc_m = opd - 8'h01;
      increment_to_acc_skip_zero: acc_m = opd + 8'h01;
      set_byte: d = 8'hFF;
      set_bit: d = opd | (8'h01 << bs);
      skip_if_bit_one: skp = opd[bs];
      swap_nibbles: d = {opd[3:0], opd[7:4]};
      default: ;
    endcase
    we = c inside {subtract_with_borrow_to_mem, difference_to_mem, decrement_skip_zero, increment_skip_zero,
      set_byte, set_bit, swap_nibbles};
    if (c inside {decrement_skip_zero, increment_skip_zero}) begin
      skp = (d == 8'h00);
    end
    if (c inside {decrement_to_acc_skip_zero, increment_to_acc_skip_zero}) begin
      skp = (acc_m == 8'h00);
    end
    op_valid = 1'b1;
    op_req = '{c, bs, opd, lit};
    @(posedge core_clk);
    #1;
    chk({1'b0, acc}, {1'b0, acc_m});
    chk({1'b0, status}, {1'b0, st_m});
    chk({mem_wr.we, we ? mem_wr.data : 8'h00}, {we, d});
    chk({7'h0, skip_dummy, op_ready}, {7'h0, skp, ~skp});
    if (skp) begin
      // A second request offered in the dummy cycle must not execute
      op_req = '{increment_to_acc_skip_zero, bs, 8'h41, lit};
      @(posedge core_clk);
      #1;
      chk({mem_wr.we, acc}, {1'b0, acc_m});
      chk({7'h0, skip_dummy, op_ready}, 9'h001);
    end
  endtask

  task automatic idle;
    op_valid = 1'b0;
    @(posedge core_clk);
    #1;
    chk({mem_wr.we, acc}, {1'b0, acc_m});
    chk({1'b0, status}, {1'b0, st_m});
    chk({7'h0, skip_dummy, op_ready}, 9'h001);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({1'b0, acc}, {1'b0, ACC_RESET});
    chk({1'b0, status}, {1'b0, STATUS_RESET});
    chk({mem_wr.we, mem_wr.data}, 9'h000);
    chk({7'h0, skip_dummy, op_ready}, 9'h001);
  endtask

  task automatic t_rotate;
    run(rotate_right_through_flag_to_acc, 3'h0, 8'h81, 8'h00);
    run(rotate_right_through_flag_to_acc, 3'h0, 8'h02, 8'h00);
    idle();
  endtask

  task automatic t_sub;
    logic [7:0] av [5] = '{8'h05, 8'h03, 8'h80, 8'h10, 8'h44};
    logic [7:0] bv [5] = '{8'h03, 8'h05, 8'h01, 8'h01, 8'h44};
    foreach (av[i]) begin
      run(increment_to_acc_skip_zero, 3'h0, av[i] - 8'h01, 8'h00);
      run(difference_to_mem, 3'h0, bv[i], 8'h00);
      run(subtract_immediate, 3'h0, 8'h5A, bv[i]);
      run(increment_to_acc_skip_zero, 3'h0, av[i] - 8'h01, 8'h00);
      run(subtract_to_acc, 3'h0, bv[i], 8'h00);
    end
    idle();
  endtask

  task automatic t_borrow;
    for (int k = 0; k < 2; k++) begin
      run(rotate_right_through_flag_to_acc, 3'h0, {7'h0, k[0]}, 8'h00);
      run(increment_to_acc_skip_zero, 3'h0, 8'h1F, 8'h00);
      run(subtract_with_borrow_to_acc, 3'h0, 8'h10, 8'h00);
      run(subtract_with_borrow_to_mem, 3'h0, 8'h30, 8'h00);
    end
    idle();
  endtask

  task automatic t_count;
    run(decrement_skip_zero, 3'h0, 8'h01, 8'h00);
    run(decrement_skip_zero, 3'h0, 8'h00, 8'h00);
    run(decrement_to_acc_skip_zero, 3'h0, 8'h01, 8'h00);
    run(decrement_to_acc_skip_zero, 3'h0, 8'h02, 8'h00);
    run(increment_skip_zero, 3'h0, 8'hFF, 8'h00);
    run(increment_skip_zero, 3'h0, 8'h7F, 8'h00);
    run(increment_to_acc_skip_zero, 3'h0, 8'hFF, 8'h00);
    idle();
  endtask

  task automatic t_bits;
    run(set_byte, 3'h0, 8'h12, 8'h00);
    for (int i = 0; i < 8; i++) begin
      run(set_bit, i[2:0], 8'h5A, 8'h00);
      run(skip_if_bit_one, i[2:0], 8'h01 << i, 8'h00);
      run(skip_if_bit_one, i[2:0], ~(8'h01 << i), 8'h00);
    end
    run(op_code_type'(4'hE), 3'h0, 8'h77, 8'h00);
    run(swap_nibbles, 3'h0, 8'h1E, 8'h00);
    idle();
  endtask

  // Reset arrives mid-cycle and must clear outputs without a clock edge
  task automatic t_mid_reset;
    run(increment_to_acc_skip_zero, 3'h0, 8'h10, 8'h00);
    idle();
    resetn = 1'b0;
    #1;
    t_reset();
    acc_m = ACC_RESET;
    st_m = STATUS_RESET;
    @(posedge core_clk);
    #1;
    resetn = 1'b1;
    run(rotate_right_through_flag_to_acc, 3'h0, 8'h03, 8'h00);
    idle();
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #10000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    t_reset();
    resetn = 1'b1;
    t_rotate();
    t_sub();
    t_borrow();
    t_count();
    t_bits();
    t_mid_reset();
    tally_and_finish();
  end
endmodule // skip_alu_tb_top
`default_nettype wire
